// ==== ucs_pkg.sv ====
// Purpose: shared constants and types for the command/status codec
// Assumes: single clock domain, active-high asynchronous reset
// Notes:   nothing here is imported; users write ucs_pkg::name
`default_nettype none
package ucs_pkg;
   // ------------------------------------------------------------
   // command byte layout
   // ------------------------------------------------------------
   localparam logic [7:0] IDLE_BYTE      = 8'h00;
   localparam int         CODE_HI        = 7;
   localparam int         CODE_LO        = 6;
   localparam int         PAY_HI         = 5;
   localparam int         PID_HI         = 3;
   localparam logic [1:0] CODE_IDLE      = 2'h0;
   localparam logic [1:0] CODE_TX        = 2'h1;
   localparam logic [1:0] CODE_WR        = 2'h2;
   localparam logic [1:0] CODE_RD        = 2'h3;
   localparam logic [5:0] PAY_ZERO       = 6'h00;
   localparam logic [5:0] PAY_EXT        = 6'h2F;
   localparam logic [1:0] PID_TOP_ZERO   = 2'h0;

   // ------------------------------------------------------------
   // status byte layout
   // ------------------------------------------------------------
   localparam int         ST_LINE_LO     = 0;
   localparam int         ST_VBUS_LO     = 2;
   localparam int         ST_EVT_LO      = 4;
   localparam int         ST_ID_BIT      = 6;
   localparam int         ST_ALT_BIT     = 7;

   // ------------------------------------------------------------
   // line-state selection
   // ------------------------------------------------------------
   localparam logic [1:0] XCVR_HS        = 2'h0;
   localparam logic [1:0] XCVR_LS        = 2'h2;
   localparam logic [1:0] OPM_CHIRP      = 2'h2;
   localparam logic [1:0] LS_SE0         = 2'h0;
   localparam logic [1:0] LS_J           = 2'h1;
   localparam logic [1:0] LS_K           = 2'h2;
   localparam logic [1:0] LS_SE1         = 2'h3;

   typedef enum logic [3:0] {
      UCS_CMD_NONE,
      UCS_CMD_NOPID,
      UCS_CMD_PID,
      UCS_CMD_REGW,
      UCS_CMD_EXTW,
      UCS_CMD_REGR,
      UCS_CMD_EXTR,
      UCS_CMD_BAD
   } ucs_cmd_t;
endpackage
`default_nettype wire

// ==== ucs_if.sv ====
// Purpose: carrier between the codec top and its two leaf modules
// Assumes: one clock domain
// Notes:   cmd group feeds the decoder, line group feeds the line-state encoder
`timescale 1ns/1ps
`default_nettype none
interface ucs_if;
   logic [7:0]       cmd_byte;
   ucs_pkg::ucs_cmd_t cmd_kind;
   logic [5:0]       cmd_addr;
   logic [3:0]       cmd_pid;
   logic [1:0]       dp_dm;
   logic             hs_rx;
   logic             squelch;
   logic             host_role;
   logic [1:0]       xcvr_sel;
   logic             term_sel;
   logic [1:0]       op_mode;
   logic [1:0]       line_state;

   modport dec_mp (input cmd_byte, output cmd_kind, output cmd_addr, output cmd_pid);
   modport ls_mp  (input dp_dm, input hs_rx, input squelch, input host_role,
                   input xcvr_sel, input term_sel, input op_mode, output line_state);
   modport top_mp (output cmd_byte, input cmd_kind, input cmd_addr, input cmd_pid,
                   output dp_dm, output hs_rx, output squelch, output host_role,
                   output xcvr_sel, output term_sel, output op_mode, input line_state);
endinterface
`default_nettype wire

// ==== ucs_cmd_decode.sv ====
// Purpose: classify one command byte
// Assumes: byte is stable while sampled
// Notes:   combinational; illegal packet payloads flag as bad
`timescale 1ns/1ps
`default_nettype none
module ucs_cmd_decode
(
   ucs_if.dec_mp u
);
   logic [1:0] code;
   logic [5:0] pay;

   assign code = u.cmd_byte[ucs_pkg::CODE_HI:ucs_pkg::CODE_LO];
   assign pay  = u.cmd_byte[ucs_pkg::PAY_HI:0];
   assign u.cmd_addr = pay;
   assign u.cmd_pid  = pay[ucs_pkg::PID_HI:0];

   always_comb
   begin
      case (code)
         ucs_pkg::CODE_IDLE:
            u.cmd_kind = (pay == ucs_pkg::PAY_ZERO) ? ucs_pkg::UCS_CMD_NONE
                                                    : ucs_pkg::UCS_CMD_BAD;
         ucs_pkg::CODE_TX:
            if (pay == ucs_pkg::PAY_ZERO)
               u.cmd_kind = ucs_pkg::UCS_CMD_NOPID;
            else if (pay[ucs_pkg::PAY_HI:ucs_pkg::PID_HI+1] == ucs_pkg::PID_TOP_ZERO)
               u.cmd_kind = ucs_pkg::UCS_CMD_PID;
            else
               u.cmd_kind = ucs_pkg::UCS_CMD_BAD;
         ucs_pkg::CODE_WR:
            u.cmd_kind = (pay == ucs_pkg::PAY_EXT) ? ucs_pkg::UCS_CMD_EXTW
                                                   : ucs_pkg::UCS_CMD_REGW;
         ucs_pkg::CODE_RD:
            u.cmd_kind = (pay == ucs_pkg::PAY_EXT) ? ucs_pkg::UCS_CMD_EXTR
                                                   : ucs_pkg::UCS_CMD_REGR;
         default:
            u.cmd_kind = ucs_pkg::UCS_CMD_BAD;
      endcase
   end
endmodule
`default_nettype wire

// ==== ucs_line_state.sv ====
// Purpose: encode the two-bit line state for host or peripheral role
// Assumes: dp_dm is the single-ended receiver pair, bit 1 = D+, bit 0 = D-
// Notes:   invalid table cells are never produced
`timescale 1ns/1ps
`default_nettype none
module ucs_line_state
(
   ucs_if.ls_mp u
);
   // the code is the receiver pair with its bits swapped: FS-J and LS-K share 01, FS-K and LS-J share 10
   function automatic logic [1:0] fs_code(input logic [1:0] pair);
      logic [1:0] r;
      r = ucs_pkg::LS_SE0;
      case (pair)
         2'h0:    r = ucs_pkg::LS_SE0;
         2'h2:    r = ucs_pkg::LS_J;
         2'h1:    r = ucs_pkg::LS_K;
         default: r = ucs_pkg::LS_SE1;
      endcase
      return r;
   endfunction

   logic hs_mode;
   logic chirp;

   assign hs_mode = (u.xcvr_sel == ucs_pkg::XCVR_HS);
   // host chirp is picked by op mode, peripheral chirp by termination
   assign chirp = u.host_role ? (u.op_mode == ucs_pkg::OPM_CHIRP) : u.term_sel;

   always_comb
   begin
      if (!hs_mode)
         u.line_state = fs_code(u.dp_dm);
      else if (u.squelch)
         u.line_state = ucs_pkg::LS_SE0;
      else if (chirp)
         u.line_state = u.hs_rx ? ucs_pkg::LS_J : ucs_pkg::LS_K;
      else
         u.line_state = ucs_pkg::LS_J;
   end
endmodule
`default_nettype wire

// ==== ucs_codec.sv ====
// Purpose: command decoder and status byte sender on the 8-bit link bus
// Assumes: link bus sampled on i_clk; far end keeps the bus protocol
// Notes:   status send takes three cycles: turnaround, byte, turnaround
//
// Contract
// - nonzero byte starts command; nxt accepts
// - zero byte is the idle no-op
// - nopid transmit starts after next byte
// - packet identifier taken from low nibble
// - extended write takes following address byte
// - register write uses six-bit payload address
// - extended read takes following address byte
// - register read uses six-bit payload address
// - status sent with dir high, one byte
// - any field change sends new status
// - stale status may drop at low-power exit
// - line, vbus, event fields in low bits
// - bit six follows the id pin
// - enabled session-valid edges set bit seven
// - line change sends updated line state
// - peripheral line state encoding by mode
// - host line state encoding by mode
// - dir high forces nxt low
`timescale 1ns/1ps
`default_nettype none
module ucs_codec
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // link bus
   input  wire logic [7:0] i_data,
   output logic      [7:0] o_data,
   output logic            o_data_oe,
   output logic            o_dir,
   output logic            o_nxt,
   input  wire logic       i_stp,
   // analog front end status
   input  wire logic [1:0] i_dp_dm,
   input  wire logic       i_hs_rx,
   input  wire logic       i_squelch,
   input  wire logic [1:0] i_vbus_state,
   input  wire logic [1:0] i_rx_event,
   input  wire logic       i_id_pin,
   input  wire logic       i_bvalid,
   input  wire logic       i_low_power,
   // configuration
   input  wire logic       i_host_role,
   input  wire logic [1:0] i_xcvr_sel,
   input  wire logic       i_term_sel,
   input  wire logic [1:0] i_op_mode,
   input  wire logic       i_bvalid_rise_en,
   input  wire logic       i_bvalid_fall_en,
   // decoded commands to the rest of the device
   output logic            o_tx_start,
   output logic            o_tx_nopid,
   output logic      [3:0] o_tx_pid,
   output logic      [7:0] o_tx_data,
   output logic            o_tx_data_vld,
   output logic            o_reg_wr,
   output logic            o_reg_rd,
   output logic      [7:0] o_reg_addr,
   output logic      [7:0] o_reg_wdata,
   input  wire logic [7:0] i_reg_rdata,
   output logic            o_cmd_bad,
   output logic      [7:0] o_status
);
   typedef enum logic [3:0] {
      UCS_IDLE,
      UCS_TX_DATA,
      UCS_EXT_ADDR,
      UCS_WR_DATA,
      UCS_RD_TURN,
      UCS_RD_DATA,
      UCS_ST_TURN,
      UCS_ST_BYTE,
      UCS_ST_BACK
   } ucs_state_t;

   ucs_if u();

   ucs_cmd_decode u_dec
   (
      .u (u.dec_mp)
   );

   ucs_line_state u_ls
   (
      .u (u.ls_mp)
   );

   assign u.cmd_byte  = i_data;
   assign u.dp_dm     = i_dp_dm;
   assign u.hs_rx     = i_hs_rx;
   assign u.squelch   = i_squelch;
   assign u.host_role = i_host_role;
   assign u.xcvr_sel  = i_xcvr_sel;
   assign u.term_sel  = i_term_sel;
   assign u.op_mode   = i_op_mode;

   ucs_state_t state_q;
   ucs_state_t state_d;
   logic       wr_kind_q;
   logic [7:0] status_now;
   logic [7:0] status_sent_q;
   logic       alt_q;
   logic       bvalid_q;
   logic       pend_q;
   logic       bv_edge;
   logic       cmd_take;

   // ------------------------------------------------------------
   // status byte assembly
   // ------------------------------------------------------------
   assign bv_edge = (i_bvalid && !bvalid_q && i_bvalid_rise_en)
                 || (!i_bvalid && bvalid_q && i_bvalid_fall_en);

   always_comb
   begin
      status_now = 8'h00;
      status_now[ucs_pkg::ST_LINE_LO +: 2] = u.line_state;
      status_now[ucs_pkg::ST_VBUS_LO +: 2] = i_vbus_state;
      status_now[ucs_pkg::ST_EVT_LO  +: 2] = i_rx_event;
      status_now[ucs_pkg::ST_ID_BIT]       = i_id_pin;
      status_now[ucs_pkg::ST_ALT_BIT]      = alt_q;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         bvalid_q <= 1'b0;
      else
         bvalid_q <= i_bvalid;
   end

   // alt bit holds through the next UCS_ST_BYTE cycle, then falls back
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         alt_q <= 1'b0;
      else if (bv_edge)
         alt_q <= 1'b1;
      else if (state_q == UCS_ST_BYTE)
         alt_q <= 1'b0;
   end

   // pending send: a change arriving during a send wins over the clear
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         pend_q <= 1'b1;
      else if (status_now != status_sent_q && !i_low_power)
         pend_q <= 1'b1;
      else if (state_q == UCS_ST_BYTE || i_low_power)
         pend_q <= 1'b0;
   end

   // latched on the turn cycle, so the byte on the bus and o_status agree
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         status_sent_q <= 8'h00;
      else if (state_q == UCS_ST_TURN || i_low_power)
         status_sent_q <= status_now;
   end

   // ------------------------------------------------------------
   // bus sequencing
   // ------------------------------------------------------------
   // a pending status wins the bus; the link sees no nxt and holds its byte
   assign cmd_take = (state_q == UCS_IDLE) && !pend_q && (i_data != ucs_pkg::IDLE_BYTE);

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         UCS_IDLE:
            if (pend_q && !i_low_power)
               state_d = UCS_ST_TURN;
            else if (cmd_take)
            begin
               case (u.cmd_kind)
                  ucs_pkg::UCS_CMD_NOPID,
                  ucs_pkg::UCS_CMD_PID:  state_d = UCS_TX_DATA;
                  ucs_pkg::UCS_CMD_EXTW,
                  ucs_pkg::UCS_CMD_EXTR: state_d = UCS_EXT_ADDR;
                  ucs_pkg::UCS_CMD_REGW: state_d = UCS_WR_DATA;
                  ucs_pkg::UCS_CMD_REGR: state_d = UCS_RD_TURN;
                  default:               state_d = UCS_IDLE;
               endcase
            end
         UCS_TX_DATA:
            if (i_stp)
               state_d = UCS_IDLE;
         UCS_EXT_ADDR:
            state_d = wr_kind_q ? UCS_WR_DATA : UCS_RD_TURN;
         UCS_WR_DATA:
            if (i_stp)
               state_d = UCS_IDLE;
         UCS_RD_TURN:
            state_d = UCS_RD_DATA;
         UCS_RD_DATA:
            state_d = UCS_ST_BACK;
         UCS_ST_TURN:
            state_d = UCS_ST_BYTE;
         UCS_ST_BYTE:
            state_d = UCS_ST_BACK;
         UCS_ST_BACK:
            state_d = UCS_IDLE;
         default:
            state_d = UCS_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         state_q <= UCS_IDLE;
      else
         state_q <= state_d;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr_kind_q <= 1'b0;
      end
      else if (cmd_take && state_d != UCS_IDLE)
      begin
         wr_kind_q <= (u.cmd_kind == ucs_pkg::UCS_CMD_EXTW);
      end
   end

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   always_comb
   begin
      o_dir = (state_q == UCS_RD_TURN) || (state_q == UCS_RD_DATA)
           || (state_q == UCS_ST_TURN) || (state_q == UCS_ST_BYTE);
      // nxt only while the bus is ours to receive; low whenever dir is high
      o_nxt = !o_dir && ((state_q == UCS_IDLE && cmd_take && state_d != UCS_IDLE)
           || ((state_q == UCS_TX_DATA || state_q == UCS_WR_DATA) && !i_stp)
           || state_q == UCS_EXT_ADDR);
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_data    <= ucs_pkg::IDLE_BYTE;
         o_data_oe <= 1'b0;
      end
      else
      begin
         o_data_oe <= (state_d == UCS_RD_DATA) || (state_d == UCS_ST_BYTE);
         if (state_d == UCS_RD_DATA)
            o_data <= i_reg_rdata;
         else if (state_d == UCS_ST_BYTE)
            o_data <= status_now;
         else
            o_data <= ucs_pkg::IDLE_BYTE;
      end
   end

   // ------------------------------------------------------------
   // decoded command outputs
   // ------------------------------------------------------------
   // a kind only counts on the edge that takes the command byte
   function automatic logic took(input logic              take,
                                 input ucs_pkg::ucs_cmd_t got,
                                 input ucs_pkg::ucs_cmd_t want);
      return take && (got == want);
   endfunction

   // packet transmit strobes and the byte stream behind them
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_tx_start    <= 1'b0;
         o_tx_nopid    <= 1'b0;
         o_tx_pid      <= 4'h0;
         o_tx_data     <= 8'h00;
         o_tx_data_vld <= 1'b0;
      end
      else
      begin
         o_tx_start    <= took(cmd_take, u.cmd_kind, ucs_pkg::UCS_CMD_PID);
         o_tx_data_vld <= (state_q == UCS_TX_DATA) && !i_stp;
         if (took(cmd_take, u.cmd_kind, ucs_pkg::UCS_CMD_PID))
            o_tx_pid <= u.cmd_pid;
         if (cmd_take)
            o_tx_nopid <= (u.cmd_kind == ucs_pkg::UCS_CMD_NOPID);
         // the stop cycle loads 00 here too; only bytes under o_tx_data_vld count
         if (state_q == UCS_TX_DATA)
            o_tx_data <= i_data;
      end
   end

   // register access strobes, address and write data
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_reg_wr    <= 1'b0;
         o_reg_rd    <= 1'b0;
         o_reg_addr  <= 8'h00;
         o_reg_wdata <= 8'h00;
      end
      else
      begin
         o_reg_wr <= (state_q == UCS_WR_DATA) && !i_stp;
         // read strobe leads the returned byte by one cycle
         o_reg_rd <= (state_d == UCS_RD_TURN);
         // immediate address is zero-extended; extended forms fill all eight bits
         if (took(cmd_take, u.cmd_kind, ucs_pkg::UCS_CMD_REGW)
          || took(cmd_take, u.cmd_kind, ucs_pkg::UCS_CMD_REGR))
            o_reg_addr <= {2'h0, u.cmd_addr};
         else if (state_q == UCS_EXT_ADDR)
            o_reg_addr <= i_data;
         if (state_q == UCS_WR_DATA)
            o_reg_wdata <= i_data;
      end
   end

   // illegal bytes are flagged and dropped; the bus stays with the link
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_cmd_bad <= 1'b0;
      else
         o_cmd_bad <= took(cmd_take, u.cmd_kind, ucs_pkg::UCS_CMD_BAD);
   end

   assign o_status = status_sent_q;
endmodule
`default_nettype wire

// ==== ucs_codec_asserts.sv ====
// Purpose: port-level checks for the command/status codec
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound into every ucs_codec instance
`timescale 1ns/1ps
`default_nettype none
module ucs_codec_asserts
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic [7:0] i_data,
   input  wire logic [7:0] o_data,
   input  wire logic       o_data_oe,
   input  wire logic       o_dir,
   input  wire logic       o_nxt,
   input  wire logic       i_id_pin,
   input  wire logic       i_low_power,
   input  wire logic       o_tx_start,
   input  wire logic [3:0] o_tx_pid,
   input  wire logic       o_reg_rd,
   input  wire logic [7:0] i_reg_rdata,
   input  wire logic [7:0] o_status
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   AST_NXT_LOW_DIR: assert property (o_dir |-> !o_nxt)
      else $error("nxt high while dir high");
   AST_OE_ONLY_DIR: assert property (o_data_oe |-> o_dir)
      else $error("bus driven without dir");
   AST_ONE_BYTE: assert property ($rose(o_dir) |-> !o_data_oe ##1 o_data_oe ##1 !o_dir)
      else $error("turnaround framing wrong");
   AST_IDLE_NOOP: assert property (!o_dir && i_data == 8'h00 && !$past(o_nxt)
      && !$past(o_dir) |-> !o_nxt)
      else $error("idle byte accepted");
   AST_BAD_REFUSED: assert property (!o_dir && !$past(o_nxt)
      && i_data[7:6] == ucs_pkg::CODE_TX && i_data[5:4] != 2'h0 |-> !o_nxt)
      else $error("illegal command accepted");
   AST_PID_TAKEN: assert property (o_tx_start |-> $past(o_nxt)
      && {4'h0, o_tx_pid} == ($past(i_data) & 8'h0F))
      else $error("packet id not from low nibble");
   AST_READ_TURN: assert property (o_reg_rd |=> o_data_oe
      && o_data == $past(i_reg_rdata))
      else $error("read byte not returned");
   AST_STATUS_BYTE: assert property ($rose(o_dir) && !$past(o_nxt) |=> o_data == o_status)
      else $error("status byte differs from latched status");
   AST_LP_QUIET: assert property (i_low_power && $past(i_low_power)
      && $past(i_low_power, 3) && !$past(o_nxt) |-> !$rose(o_dir))
      else $error("status sent in low power");
   AST_ID_SENT: assert property ($changed(i_id_pin) && !i_low_power
      |-> ##[1:12] (o_data_oe && o_data[6] == i_id_pin))
      else $error("id change not reported");
endmodule

bind ucs_codec ucs_codec_asserts chk
(
   .i_clk, .i_rst, .i_data, .o_data, .o_data_oe, .o_dir, .o_nxt, .i_id_pin,
   .i_low_power, .o_tx_start, .o_tx_pid, .o_reg_rd, .i_reg_rdata, .o_status
);
`default_nettype wire

// ==== ucs_link_model.sv ====
// Purpose: link controller on the far side of the 8-bit bus
// Assumes: device answers with nxt, turns the bus with dir
// Notes:   transfers are started right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ucs_link_model
(
   input  wire logic       i_clk,
   input  wire logic       i_dir,
   input  wire logic       i_nxt,
   input  wire logic       i_oe,
   input  wire logic [7:0] i_dev,
   output logic      [7:0] o_bus,
   output logic            o_stp
);
   logic [7:0] drv_q = 8'h00;
   logic [7:0] rx_q  = 8'h00;
   int         rx_n  = 0;

   initial o_stp = 1'b0;
   // released bus shows the inverse of our last byte, never a kind stale copy
   assign o_bus = i_dir ? (i_oe ? i_dev : ~drv_q) : drv_q;

   always @(posedge i_clk)
   begin
      if (i_dir && i_oe)
      begin
         rx_q <= i_dev;
         rx_n <= rx_n + 1;
      end
   end

   // ------------------------------------------------------------
   // one command: hold each byte until nxt is seen at an edge
   // ------------------------------------------------------------
   task automatic xfer(input logic [7:0] b [4], input int n, input bit rd, output bit ok);
      int k;
      int t;
      int c;
      ok = 1'b1;
      c = rx_n;
      for (k = 0; k < n; k++)
      begin
         drv_q <= b[k];
         t = 0;
         @(posedge i_clk);
         while (!i_nxt && t < 20)
         begin
            @(posedge i_clk);
            t++;
         end
         ok &= (t < 20);
      end
      drv_q <= 8'h00;
      o_stp <= !rd && ok;
      @(posedge i_clk);
      o_stp <= 1'b0;
      t = 0;
      while (rd && rx_n == c && t < 10)
      begin
         @(posedge i_clk);
         t++;
      end
      ok &= (t < 10);
   endtask
endmodule
`default_nettype wire

// ==== ucs_codec_tb.sv ====
// Purpose: self-checking bench for the command/status codec
// Assumes: 20 MHz clock, reset held four cycles
// Notes:   status bytes are predicted from the front-end inputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end
module ucs_codec_tb;
   logic        clk = 1'b0, rst = 1'b1, hs_rx = 1'b0, sq = 1'b0, id = 1'b0;
   logic        bval = 1'b0, lp = 1'b0, host = 1'b0, term = 1'b1, ren = 1'b0, fen = 1'b0;
   logic [1:0]  dp_dm = 2'h2, vbus = 2'h0, evt = 2'h0, xsel = 2'h1, opm = 2'h0;
   logic [7:0]  rdata = 8'h00, bus, o_data, o_status, o_reg_addr, o_reg_wdata, wa, wd, ra;
   logic [7:0]  o_tx_data, td;
   logic [3:0]  o_tx_pid, pid;
   logic        stp, o_data_oe, o_dir, o_nxt, o_tx_start, o_tx_nopid, o_tx_data_vld;
   logic        o_reg_wr, o_reg_rd, o_cmd_bad;
   logic [31:0] seed = 32'h1B22;
   int          cnt [5] = '{default: 0};
   int          err_total = 0, comparisons = 0, i, n, t, k;

   always #25 clk = ~clk;

   ucs_codec uut (.i_clk(clk), .i_rst(rst), .i_data(bus), .o_data(o_data),
      .o_data_oe(o_data_oe), .o_dir(o_dir), .o_nxt(o_nxt), .i_stp(stp), .i_dp_dm(dp_dm),
      .i_hs_rx(hs_rx), .i_squelch(sq), .i_vbus_state(vbus), .i_rx_event(evt),
      .i_id_pin(id), .i_bvalid(bval), .i_low_power(lp), .i_host_role(host),
      .i_xcvr_sel(xsel), .i_term_sel(term), .i_op_mode(opm), .i_bvalid_rise_en(ren),
      .i_bvalid_fall_en(fen), .o_tx_start(o_tx_start), .o_tx_nopid(o_tx_nopid),
      .o_tx_pid(o_tx_pid), .o_tx_data(o_tx_data), .o_tx_data_vld(o_tx_data_vld),
      .o_reg_rd(o_reg_rd), .o_reg_addr(o_reg_addr), .o_reg_wdata(o_reg_wdata),
      .o_reg_wr(o_reg_wr), .i_reg_rdata(rdata), .o_cmd_bad(o_cmd_bad), .o_status(o_status));
   ucs_link_model link (.i_clk(clk), .i_dir(o_dir), .i_nxt(o_nxt), .i_oe(o_data_oe),
      .i_dev(o_data), .o_bus(bus), .o_stp(stp));

   always @(posedge clk)
   begin
      cnt[0] <= cnt[0] + int'(o_reg_wr === 1'b1);
      cnt[1] <= cnt[1] + int'(o_reg_rd === 1'b1);
      cnt[2] <= cnt[2] + int'(o_tx_start === 1'b1);
      cnt[3] <= cnt[3] + int'(o_tx_data_vld === 1'b1);
      cnt[4] <= cnt[4] + int'(o_cmd_bad === 1'b1);
      if (o_reg_wr === 1'b1) {wa, wd} <= {o_reg_addr, o_reg_wdata};
      if (o_reg_rd === 1'b1) ra <= o_reg_addr;
      if (o_tx_start === 1'b1) pid <= o_tx_pid;
      if (o_tx_data_vld === 1'b1) td <= o_tx_data;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // ------------------------------------------------------------
   // reference status byte, host or peripheral encoding
   // ------------------------------------------------------------
   function automatic logic [7:0] exp_status(input logic alt);
      logic [1:0] ls;
      if (xsel != ucs_pkg::XCVR_HS) ls = {dp_dm[0], dp_dm[1]};
      else if (sq) ls = ucs_pkg::LS_SE0;
      else if (host ? opm == ucs_pkg::OPM_CHIRP : term) ls = hs_rx ? 2'h1 : 2'h2;
      else ls = 2'h1;
      return {alt, id, evt, vbus, ls};
   endfunction

   task automatic settle();
      int q;
      int w;
      q = 0;
      w = 0;
      while (q < 6 && w < 60)
      begin
         @(posedge clk);
         q = o_dir ? 0 : q + 1;
         w++;
      end
   endtask

   task automatic do_cmd(input int k);
      logic [31:0] r;
      logic [7:0]  b [4];
      logic [5:0]  a;
      logic [7:0]  ea;
      int          m;
      int          c0 [5];
      bit          ok;
      r = xs();
      a = (r[5:0] == ucs_pkg::PAY_EXT) ? 6'h00 : r[5:0];
      b = '{8'h00, r[15:8], r[23:16], 8'h00};
      ea = (k == 1 || k == 3) ? b[1] : {2'h0, a};
      m = (k == 2 || k == 6) ? 1 : (k == 1 || k == 4) ? 3 : 2;
      case (k)
         0: b[0] = {ucs_pkg::CODE_WR, a};
         1: b[0] = {ucs_pkg::CODE_WR, ucs_pkg::PAY_EXT};
         2: b[0] = {ucs_pkg::CODE_RD, a};
         3: b[0] = {ucs_pkg::CODE_RD, ucs_pkg::PAY_EXT};
         4: b[0] = {ucs_pkg::CODE_TX, 2'h0, r[3:0] | 4'h1};
         5: b[0] = {ucs_pkg::CODE_TX, ucs_pkg::PAY_ZERO};
         default: b[0] = {ucs_pkg::CODE_TX, 2'h1, r[3:0]};
      endcase
      rdata <= r[31:24];
      c0 = cnt;
      link.xfer(b, m, k == 2 || k == 3, ok);
      repeat (3) @(posedge clk);
      `CHK(ok, k != 6)
      if (k < 2)
      begin
         `CHK(cnt[0], c0[0] + 1)
         `CHK({wa, wd}, {ea, b[m - 1]})
      end
      else if (k < 4)
      begin
         `CHK(cnt[1], c0[1] + 1)
         `CHK({ra, link.rx_q}, {ea, r[31:24]})
      end
      else if (k < 6)
      begin
         `CHK(cnt[3], c0[3] + m - 1)
         `CHK(td, b[m - 1])
         if (k == 4) `CHK(cnt[2], c0[2] + 1)
         `CHK(k == 4 ? pid : {3'h0, o_tx_nopid}, k == 4 ? b[0][3:0] : 4'h1)
      end
      else
         `CHK(cnt[4] > c0[4], 1'b1)
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      #300000;
      err_total++;
      tally_and_finish();
   end

   initial
   begin
      logic [31:0] r;
      logic [1:0]  xv;
      logic        tv;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      settle();
      `CHK(link.rx_q, exp_status(1'b0))
      $display("test reset status finished");
      lp <= 1'b1;
      settle();
      n = link.rx_n;
      id <= 1'b1;
      repeat (10) @(posedge clk);
      `CHK(link.rx_n, n)
      lp <= 1'b0;
      dp_dm <= 2'h1;
      settle();
      `CHK(link.rx_q, exp_status(1'b0))
      $display("test low power finished");
      for (i = 0; i < 2; i++)
      begin
         ren <= (i == 0);
         fen <= (i == 1);
         @(posedge clk);
         n = link.rx_n;
         bval <= (i == 0);
         t = 0;
         while (link.rx_n == n && t < 20)
         begin
            @(posedge clk);
            t++;
         end
         `CHK(link.rx_q, exp_status(1'b1))
         settle();
         `CHK(link.rx_q, exp_status(1'b0))
      end
      $display("test session edge flag finished");
      for (i = 0; i < 24; i++)
      begin
         r = xs();
         xv = (!r[0] && r[2:1] == ucs_pkg::XCVR_LS) ? 2'h1 : r[2:1];
         tv = r[0] ? (xv != 2'h0) : (xv != 2'h0 || r[3]);
         host <= r[0];
         xsel <= xv;
         term <= tv;
         opm <= (!r[0] && xv == 2'h0) ? {tv, 1'b0} : r[5:4];
         dp_dm <= r[7:6];
         hs_rx <= r[8];
         sq <= r[9];
         vbus <= r[11:10];
         evt <= r[13:12];
         id <= r[14];
         @(posedge clk);
         settle();
         `CHK(link.rx_q, exp_status(1'b0))
      end
      $display("test status changes finished");
      for (i = 0; i < 14; i++)
      begin
         k = i % 7;
         do_cmd(k);
      end
      $display("test commands finished");
      tally_and_finish();
   end
endmodule
`default_nettype wire
